// ---- rtl/weight_setpoint_controller.sv ----
`timescale 1ns/1ns
module weight_setpoint_controller import setpoint_pkg::*; #(
  parameter int W = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic weight_valid,
  input wire logic [W-1:0] gross_weight,
  input wire logic [W-1:0] displayed_weight,
  input wire logic halt_in,
  input wire logic resume_in,
  output logic coarse_flow_out,
  output logic trickle_flow_out
);

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [W-1:0] target;
    logic [W-1:0] preact;
    logic [W-1:0] fine_band;
    fill_state_type state;
    logic coarse;
    logic trickle;
    logic [DATA_W-1:0] rdata;
  } top_state_type;

  top_state_type s_r;
  top_state_type s_nxt;

  logic [W+1:0] first_cutoff_point;
  logic [W+1:0] second_cutoff_point;
  logic single_speed;
  logic cp1_reached;
  logic cp2_reached;
  logic sample_seen;
  logic enable;
  logic mode_indep;
  logic latch_en;
  logic filling;

  assign enable = s_r.ctrl[CTRL_ENABLE];
  assign mode_indep = s_r.ctrl[CTRL_MODE_INDEP];
  assign latch_en = s_r.ctrl[CTRL_LATCH_EN];
  // no sample yet means no known weight, so valves stay shut
  assign filling = enable && sample_seen;

  cutoff_calc #(
    .W(W)
  ) u_calc (
    .clk(clk),
    .rst_n(rst_n),
    .target(s_r.target),
    .preact(s_r.preact),
    .fine_band(s_r.fine_band),
    .cp1(first_cutoff_point),
    .cp2(second_cutoff_point),
    .single_speed(single_speed)
  );

  weight_compare #(
    .W(W)
  ) u_cmp (
    .clk(clk),
    .rst_n(rst_n),
    .weight_valid(weight_valid),
    .src_displayed(s_r.ctrl[CTRL_SRC_DISPLAYED]),
    .gross_weight(gross_weight),
    .displayed_weight(displayed_weight),
    .cp1(first_cutoff_point),
    .cp2(second_cutoff_point),
    .cp1_reached(cp1_reached),
    .cp2_reached(cp2_reached),
    .sample_seen(sample_seen)
  );

  // weight fields read back zero-extended in the low bits
  function automatic logic [DATA_W-1:0] wide(input logic [W-1:0] v);
    wide = DATA_W'(v);
  endfunction

  // cutoff points read back as their low W bits, zero-extended; the two extension bits are dropped
  function automatic logic [DATA_W-1:0] wide_cp(input logic [W+1:0] v);
    wide_cp = DATA_W'(v[W-1:0]);
  endfunction

  // read multiplexer; unmapped addresses answer zero
  function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] a, input top_state_type s,
                                                 input logic [W+1:0] c1, input logic [W+1:0] c2,
                                                 input logic [7:0] st);
    if (a == ADDR_CTRL) begin
      read_mux = DATA_W'(s.ctrl);
    end else if (a == ADDR_TARGET) begin
      read_mux = wide(s.target);
    end else if (a == ADDR_PREACT) begin
      read_mux = wide(s.preact);
    end else if (a == ADDR_FINE_BAND) begin
      read_mux = wide(s.fine_band);
    end else if (a == ADDR_STATUS) begin
      read_mux = DATA_W'(st);
    end else if (a == ADDR_CP1) begin
      read_mux = wide_cp(c1);
    end else if (a == ADDR_CP2) begin
      read_mux = wide_cp(c2);
    end else begin
      read_mux = '0;
    end
  endfunction

  logic [7:0] status_bits;

  // live status snapshot
  always_comb begin
    status_bits = '0;
    status_bits[STAT_FAST] = s_r.coarse;
    status_bits[STAT_FINE] = s_r.trickle;
    status_bits[STAT_STATE_HI:STAT_STATE_LO] = s_r.state;
    status_bits[STAT_CP1_REACHED] = cp1_reached;
    status_bits[STAT_CP2_REACHED] = cp2_reached;
    status_bits[STAT_SEEN] = sample_seen;
    status_bits[STAT_SINGLE] = single_speed;
  end

  // register writes, sequence state and valve outputs
  always_comb begin
    logic want_coarse;
    logic want_trickle;
    want_coarse = 1'b0;
    want_trickle = 1'b0;
    s_nxt = s_r;

    // register port writes
    if (reg_wr) begin
      if (reg_addr == ADDR_CTRL) begin
        s_nxt.ctrl = reg_wdata[CTRL_W-1:0];
      end else if (reg_addr == ADDR_TARGET) begin
        s_nxt.target = reg_wdata[W-1:0];
      end else if (reg_addr == ADDR_PREACT) begin
        s_nxt.preact = reg_wdata[W-1:0];
      end else if (reg_addr == ADDR_FINE_BAND) begin
        s_nxt.fine_band = reg_wdata[W-1:0];
      end
    end

    // read data stands only in the cycle after the strobe
    s_nxt.rdata = reg_rd ? read_mux(reg_addr, s_r, first_cutoff_point, second_cutoff_point, status_bits) : '0;

    // halt wins over resume when both arrive together
    if (!latch_en) begin
      s_nxt.state = ST_RUN;
    end else if (halt_in) begin
      s_nxt.state = ST_HALTED;
    end else begin
      case (s_r.state)
        ST_RUN: begin
          if (filling && cp2_reached) begin
            s_nxt.state = ST_LATCHED;
          end
        end
        ST_LATCHED: begin
          if (resume_in) begin
            s_nxt.state = ST_RUN;
          end
        end
        ST_HALTED: begin
          if (resume_in) begin
            s_nxt.state = ST_RUN;
          end
        end
        default: begin
          s_nxt.state = ST_RUN;
        end
      endcase
    end

    // output pattern from the comparison
    if (single_speed) begin
      want_coarse = 1'b0;
      want_trickle = !cp2_reached;
    end else if (mode_indep) begin
      want_coarse = !cp1_reached;
      want_trickle = cp1_reached && !cp2_reached;
    end else begin
      want_coarse = !cp1_reached;
      want_trickle = !cp2_reached;
    end

    // outputs only while running; latched or halted forces them off
    s_nxt.coarse = filling && (s_nxt.state == ST_RUN) && want_coarse;
    s_nxt.trickle = filling && (s_nxt.state == ST_RUN) && want_trickle;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r.ctrl <= CTRL_RESET;
      s_r.target <= TARGET_RESET[W-1:0];
      s_r.preact <= PREACT_RESET[W-1:0];
      s_r.fine_band <= FINE_BAND_RESET[W-1:0];
      s_r.state <= ST_RUN;
      s_r.coarse <= 1'b0;
      s_r.trickle <= 1'b0;
      s_r.rdata <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign coarse_flow_out = s_r.coarse;
  assign trickle_flow_out = s_r.trickle;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // run conditions shared by several checks
  sequence s_running;
    filling && !latch_en && !reg_wr;
  endsequence

  sequence s_enter_halt;
    latch_en && halt_in && !reg_wr;
  endsequence

  property p_single;
    single_speed |=> !coarse_flow_out;
  endproperty
  a_single: assert property (p_single) else $error("coarse on in single speed");

  property p_conc_below;
    s_running and (!mode_indep && !single_speed && !cp1_reached) |=> coarse_flow_out && trickle_flow_out;
  endproperty
  a_conc_below: assert property (p_conc_below) else $error("concurrent low fill wrong");

  property p_conc_between;
    s_running and (!mode_indep && !single_speed && cp1_reached && !cp2_reached)
      |=> !coarse_flow_out && trickle_flow_out;
  endproperty
  a_conc_between: assert property (p_conc_between) else $error("concurrent band fill wrong");

  property p_stop;
    cp2_reached |=> !coarse_flow_out && !trickle_flow_out;
  endproperty
  a_stop: assert property (p_stop) else $error("output on past second cutoff");

  property p_indep;
    mode_indep && $past(mode_indep) |-> !(coarse_flow_out && trickle_flow_out);
  endproperty
  a_indep: assert property (p_indep) else $error("independent outputs overlap");

  property p_indep_coarse;
    s_running and (mode_indep && !single_speed && !cp1_reached) |=> coarse_flow_out && !trickle_flow_out;
  endproperty
  a_indep_coarse: assert property (p_indep_coarse) else $error("independent coarse phase wrong");

  property p_latch_hold;
    latch_en && s_r.state == ST_LATCHED && !resume_in |=> s_r.state == ST_LATCHED || s_r.state == ST_HALTED;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch released without resume");

  property p_latched_off;
    s_r.state != ST_RUN |-> !coarse_flow_out && !trickle_flow_out;
  endproperty
  a_latched_off: assert property (p_latched_off) else $error("output on while latched or halted");

  property p_resume;
    latch_en && !halt_in && !reg_wr && resume_in && s_r.state == ST_LATCHED |=> s_r.state == ST_RUN;
  endproperty
  a_resume: assert property (p_resume) else $error("resume did not clear latch");

  property p_halt;
    s_enter_halt |=> s_r.state == ST_HALTED && !coarse_flow_out && !trickle_flow_out;
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not stop outputs");

  property p_halt_stay;
    s_enter_halt ##1 (latch_en && !resume_in && !reg_wr) |=> s_r.state == ST_HALTED;
  endproperty
  a_halt_stay: assert property (p_halt_stay) else $error("halt left without resume");

  property p_no_latch;
    !latch_en && !reg_wr |=> s_r.state == ST_RUN;
  endproperty
  a_no_latch: assert property (p_no_latch) else $error("halt or latch acted with latch off");

  property p_read;
    reg_rd && reg_addr == ADDR_CTRL |=> reg_rdata == DATA_W'($past(s_r.ctrl));
  endproperty
  a_read: assert property (p_read) else $error("control readback wrong");

endmodule // weight_setpoint_controller

// ---- rtl/setpoint_pkg.sv ----
package setpoint_pkg;

  // register map, byte addresses on the plain register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_TARGET = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PREACT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_FINE_BAND = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_CP1 = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_CP2 = 8'h18;

  // control register fields
  localparam int CTRL_W = 4;
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_MODE_INDEP = 1;
  localparam int CTRL_SRC_DISPLAYED = 2;
  localparam int CTRL_LATCH_EN = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

  // status register fields
  localparam int STAT_FAST = 0;
  localparam int STAT_FINE = 1;
  localparam int STAT_STATE_LO = 2;
  localparam int STAT_STATE_HI = 3;
  localparam int STAT_CP1_REACHED = 4;
  localparam int STAT_CP2_REACHED = 5;
  localparam int STAT_SEEN = 6;
  localparam int STAT_SINGLE = 7;

  // reset values of the weight settings
  localparam logic [DATA_W-1:0] TARGET_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] PREACT_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] FINE_BAND_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_LATCHED = 2'b01,
    ST_HALTED = 2'b10
  } fill_state_type;

endpackage

// ---- rtl/cutoff_calc.sv ----
`timescale 1ns/1ns
module cutoff_calc import setpoint_pkg::*; #(
  parameter int W = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] target,
  input wire logic [W-1:0] preact,
  input wire logic [W-1:0] fine_band,
  output logic [W+1:0] cp1,
  output logic [W+1:0] cp2,
  output logic single_speed
);

  typedef struct packed {
    logic [W+1:0] cp1;
    logic [W+1:0] cp2;
    logic single;
  } calc_state_type;

  calc_state_type s_r;
  calc_state_type s_nxt;

  // sign-extend by two bits so the double subtraction cannot wrap
  function automatic logic [W+1:0] ext(input logic [W-1:0] v);
    ext = {{2{v[W-1]}}, v};
  endfunction

  // both cutoff points from the settings
  always_comb begin
    s_nxt = s_r;
    s_nxt.cp2 = ext(target) - ext(preact);
    s_nxt.cp1 = ext(target) - ext(preact) - ext(fine_band);
    s_nxt.single = (fine_band == '0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cp1 = s_r.cp1;
  assign cp2 = s_r.cp2;
  assign single_speed = s_r.single;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_cutoffs;
    1'b1 |=> (cp1 == ext($past(target)) - ext($past(preact)) - ext($past(fine_band)))
      && (cp2 == ext($past(target)) - ext($past(preact)));
  endproperty
  a_cutoffs: assert property (p_cutoffs) else $error("cutoff points wrong");

endmodule // cutoff_calc

// ---- rtl/weight_compare.sv ----
`timescale 1ns/1ns
module weight_compare import setpoint_pkg::*; #(
  parameter int W = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic weight_valid,
  input wire logic src_displayed,
  input wire logic [W-1:0] gross_weight,
  input wire logic [W-1:0] displayed_weight,
  input wire logic [W+1:0] cp1,
  input wire logic [W+1:0] cp2,
  output logic cp1_reached,
  output logic cp2_reached,
  output logic sample_seen
);

  typedef struct packed {
    logic cp1_reached;
    logic cp2_reached;
    logic seen;
  } cmp_state_type;

  cmp_state_type s_r;
  cmp_state_type s_nxt;
  logic [W+1:0] sel_ext;

  // chosen source, widened to the cutoff width
  assign sel_ext = src_displayed ? {{2{displayed_weight[W-1]}}, displayed_weight}
                                 : {{2{gross_weight[W-1]}}, gross_weight};

  // flags only move on a new sample; between samples they hold
  always_comb begin
    s_nxt = s_r;
    if (weight_valid) begin
      s_nxt.cp1_reached = ($signed(sel_ext) >= $signed(cp1));
      s_nxt.cp2_reached = ($signed(sel_ext) >= $signed(cp2));
      s_nxt.seen = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cp1_reached = s_r.cp1_reached;
  assign cp2_reached = s_r.cp2_reached;
  assign sample_seen = s_r.seen;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_compare;
    weight_valid |=> (cp2_reached == ($signed($past(sel_ext)) >= $signed($past(cp2))))
      && (cp1_reached == ($signed($past(sel_ext)) >= $signed($past(cp1))));
  endproperty
  a_compare: assert property (p_compare) else $error("compare flags wrong");

  property p_hold;
    !weight_valid |=> $stable(cp1_reached) && $stable(cp2_reached);
  endproperty
  a_hold: assert property (p_hold) else $error("flags moved without sample");

endmodule // weight_compare

// ---- tb/valve_station.sv ----
`timescale 1ns/1ns
// far-side filling equipment: drives the discrete halt and resume lines
module valve_station (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stop_req,
  input wire logic go_req,
  output logic halt_in,
  output logic resume_in
);
  logic go_d_r;
  // halt is a level; resume is one pulse per new request, the shortest the device must accept
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_in <= 1'b0;
      resume_in <= 1'b0;
      go_d_r <= 1'b0;
    end else begin
      halt_in <= stop_req;
      resume_in <= go_req && !go_d_r;
      go_d_r <= go_req;
    end
  end
endmodule // valve_station

// ---- tb/test_weight_setpoint_controller.sv ----
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
module test_weight_setpoint_controller import setpoint_pkg::*;;
  logic clk, rst_n, reg_wr, reg_rd, weight_valid, stop_req, go_req, halt_in, resume_in;
  logic coarse_flow_out, trickle_flow_out;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, v;
  logic [23:0] gross_weight, displayed_weight;
  int errors, checks_done, tg, pa, bd, lw, st, s1, s2;
  int seed = 32'hdb922648;
  bit en, mode, src, lat;

  weight_setpoint_controller #(.W(24)) weight_setpoint_controller_i (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .weight_valid(weight_valid), .gross_weight(gross_weight),
    .displayed_weight(displayed_weight), .halt_in(halt_in), .resume_in(resume_in),
    .coarse_flow_out(coarse_flow_out), .trickle_flow_out(trickle_flow_out));
  valve_station valve_station_i (.clk(clk), .rst_n(rst_n), .stop_req(stop_req), .go_req(go_req),
    .halt_in(halt_in), .resume_in(resume_in));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // bounded run: the whole sequence needs under two thousand cycles
  initial begin
    #200000;
    errors++;
    stop_test();
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // model latch entry: cutoff two reached while running
  task automatic upd();
    if (lat && st == 0 && lw >= tg - pa) st = 1;
  endtask

  // reference of both valve outputs from the last weight and the model state
  task automatic cmp();
    logic r1, r2, sg, ec, et;
    r1 = lw >= tg - pa - bd;
    r2 = lw >= tg - pa;
    sg = bd == 0;
    ec = !r1 && !sg;
    et = (mode && !sg) ? (r1 && !r2) : !r2;
    if (!en || st != 0) begin
      ec = 1'b0;
      et = 1'b0;
    end
    `CHK("coarse", ec, coarse_flow_out)
    `CHK("trickle", et, trickle_flow_out)
  endtask

  // the unselected bus carries 3000 minus the weight, which lies past both cutoffs
  task automatic smp(input int w);
    @(posedge clk);
    weight_valid <= 1'b1;
    gross_weight <= src ? 24'(3000 - w) : 24'(w);
    displayed_weight <= src ? 24'(w) : 24'(3000 - w);
    @(posedge clk);
    weight_valid <= 1'b0;
    repeat (3) @(posedge clk);
    #1 lw = w;
    upd();
    cmp();
  endtask

  task automatic go();
    @(posedge clk);
    go_req <= 1'b1;
    @(posedge clk);
    go_req <= 1'b0;
    repeat (4) @(posedge clk);
    #1 if (lat) st = 0;
    upd();
  endtask

  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, weight_valid, stop_req, go_req} = 5'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    gross_weight = 24'h0;
    displayed_weight = 24'h0;
    {en, mode, src, lat} = 4'h0;
    {tg, pa, bd, st} = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_TARGET, v);
    `CHK("target_rst", TARGET_RESET, v)
    rd(8'h1c, v);
    `CHK("unmapped", 32'h0, v)
    smp(-5); // outputs stay off while disabled; below zero cutoffs so no stale reached flag
    for (int cfg = 0; cfg < 16; cfg++) begin
      mode = cfg[0];
      src = cfg[1];
      bd = cfg[3] ? 0 : 100 + ($random(seed) & 63);
      tg = 1000 + ($random(seed) & 255);
      pa = 20 + ($random(seed) & 15);
      s1 = tg - pa - bd;
      s2 = tg - pa;
      wr(ADDR_TARGET, 32'(tg));
      wr(ADDR_PREACT, 32'(pa));
      wr(ADDR_FINE_BAND, 32'(bd));
      // clear any latched state from the previous setup before the real one
      en = 1;
      lat = 1;
      wr(ADDR_CTRL, {28'h0, 1'b1, src, mode, 1'b1});
      smp(-500);
      go();
      lat = cfg[2];
      wr(ADDR_CTRL, {28'h0, lat, src, mode, 1'b1});
      wr(ADDR_CP1, 32'h0);
      rd(ADDR_CP1, v);
      `CHK("cp1", 32'(s1) & 32'h00ff_ffff, v)
      rd(ADDR_CP2, v);
      `CHK("cp2", 32'(s2) & 32'h00ff_ffff, v)
      smp(s1 - 1);
      smp(s1);
      smp(s2 - 1);
      smp(s2);
      smp(s2 + 3);
      smp(s1 - 1);
      smp(s2 - 1);
      go();
      cmp();
      repeat (4) smp(s1 - 40 + ($random(seed) & 63));
      // halt in mid-fill, then resume
      smp(s1 - 10);
      stop_req <= 1'b1;
      repeat (4) @(posedge clk);
      #1 if (lat) st = 2;
      cmp();
      stop_req <= 1'b0;
      smp(s1 - 10);
      go();
      cmp();
    end
    stop_test();
  end
endmodule // test_weight_setpoint_controller
